/* logic/acsi_pkg.sv */
// Purpose: shared constants for the audio codec serial interface
// Assumes: 100 MHz ref_clk
// Notes:   clock divider figures approximate the codec clocks
package acsi_pkg;
  localparam int          REF_CLK_HZ     = 100_000_000;
  localparam int          MCLK_HZ        = 12_288_000;
  localparam int          FS_HZ          = 48_000;
  localparam int          FS_MIN_HZ      = 8_000;
  localparam int          FS_MAX_HZ      = 96_000;
  localparam int          SAMPLE_W       = 24;
  localparam int          SLOT_W         = 32;
  localparam int          BCLK_HALF      = REF_CLK_HZ / (FS_HZ * SLOT_W * 2 * 2);
  localparam int          MCLK_ACC_W     = 16;
  localparam logic [15:0] MCLK_ACC_INC   = 16'(((MCLK_HZ / 1000) * 65536) / (REF_CLK_HZ / 1000));
  localparam logic [6:0]  CODEC_I2C_ADDR = 7'h1A;
  localparam int          CFG_CNT_W      = 8;
  localparam int          SETTLE_FRAMES  = 4;
endpackage

/* logic/acsi_shift.sv */
// Purpose: serializer/deserializer for one I2S channel pair
// Assumes: bit clock edges arrive as one-cycle pulses in ref_clk domain
// Notes:   data starts one bit clock after channel clock change
`timescale 1ns/10ps
module acsi_shift import acsi_pkg::*; #(
  parameter int WIDTH = SAMPLE_W
) (
  input  wire logic             ref_clk,    // system clock
  input  wire logic             arst_n,     // async reset
  input  wire logic             ce,         // clock enable
  input  wire logic             bclk_fall,  // shift out strobe
  input  wire logic             bclk_rise,  // sample strobe
  input  wire logic             lrc,        // channel clock level
  input  wire logic             rx_bit,     // synchronised record data
  input  wire logic [WIDTH-1:0] tx_left,    // playback left
  input  wire logic [WIDTH-1:0] tx_right,   // playback right
  output logic                  tx_bit,     // playback data bit
  output logic [WIDTH-1:0]      rx_left,    // record left
  output logic [WIDTH-1:0]      rx_right,   // record right
  output logic                  rx_valid,   // stereo pair ready
  output logic                  tx_load     // tx_left loaded; tx_right loaded at next change
);
  logic             lrc_reg;
  logic [WIDTH-1:0] tx_sh_reg;
  logic [WIDTH-1:0] rx_sh_reg;
  logic [5:0]       bit_cnt_reg;
  logic             lrc_chg;
  logic [WIDTH-1:0] tx_pick;
  assign lrc_chg = (lrc != lrc_reg);
  assign tx_pick = lrc ? tx_right : tx_left;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrc_reg     <= 1'b0;
      tx_sh_reg   <= '0;
      tx_bit      <= 1'b0;
      bit_cnt_reg <= '0;
    end else if (ce && bclk_fall) begin
      lrc_reg <= lrc;
      if (lrc_chg) begin
        // first bit goes out one bit clock after the change
        tx_sh_reg   <= tx_pick;
        bit_cnt_reg <= '0;
        tx_bit      <= 1'b0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
        tx_bit      <= (bit_cnt_reg < 6'(WIDTH)) ? tx_sh_reg[WIDTH-1] : 1'b0;
        tx_sh_reg   <= {tx_sh_reg[WIDTH-2:0], 1'b0};
      end
    end
  end

  logic [5:0] rx_cnt_reg;
  logic       rx_lrc_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_cnt_reg <= '0;
      rx_lrc_reg <= 1'b0;
      rx_sh_reg  <= '0;
      rx_left    <= '0;
      rx_right   <= '0;
      rx_valid   <= 1'b0;
      tx_load    <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      tx_load  <= 1'b0;
      if (bclk_rise) begin
        rx_lrc_reg <= lrc;
        if (lrc != rx_lrc_reg) begin
          // word for previous channel complete
          rx_cnt_reg <= '0;
          if (rx_lrc_reg) begin
            rx_right <= rx_sh_reg;
            rx_valid <= 1'b1;
            tx_load  <= 1'b1;
          end else begin
            rx_left <= rx_sh_reg;
          end
        end else if (rx_cnt_reg < 6'(WIDTH)) begin
          rx_cnt_reg <= rx_cnt_reg + 6'h01;
          rx_sh_reg  <= {rx_sh_reg[WIDTH-2:0], rx_bit};
        end
      end
    end
  end
endmodule

/* logic/acsi_top.sv */
// Purpose: logic-side I2S link and clocks for a stereo audio codec
// Assumes: codec configured by an external I2C agent; ref_clk 100 MHz
// Notes:   slave mode generates bit/channel clocks; master mode samples them
`timescale 1ns/10ps
module acsi_top import acsi_pkg::*; #(
  parameter int WIDTH = SAMPLE_W
) (
  input  wire logic             ref_clk,        // 100 MHz clock
  input  wire logic             arst_n,         // async reset, active low
  input  wire logic             ce,             // clock enable
  input  wire logic             codec_master,   // 1: codec makes serial clocks
  input  wire logic             cfg_done,       // codec configuration finished
  input  wire logic             unmute_req,     // user wants audio out
  input  wire logic [WIDTH-1:0] play_left,      // playback left sample
  input  wire logic [WIDTH-1:0] play_right,     // playback right sample
  output logic                  play_take,      // play_left taken; play_right taken one slot later
  output logic [WIDTH-1:0]      rec_left,       // record left sample
  output logic [WIDTH-1:0]      rec_right,      // record right sample
  output logic                  rec_valid,      // record pair ready
  output logic                  mclk,           // codec master clock
  input  wire logic             bclk_i,         // bit clock pin in
  output logic                  bclk_o,         // bit clock pin out
  output logic                  bclk_oe,        // bit clock drive enable
  input  wire logic             playback_channel_clock_i,  // channel clock in
  output logic                  playback_channel_clock_o,  // channel clock out
  output logic                  playback_channel_clock_oe, // drive enable
  input  wire logic             record_channel_clock_i,    // record channel clock in
  output logic                  record_channel_clock_o,    // record channel clock out
  output logic                  record_channel_clock_oe,   // drive enable
  output logic                  playback_serial_data,      // playback data
  input  wire logic             record_serial_data,        // record data
  output logic                  mute_n                     // analog enable, low mutes
);
  // master clock from a phase accumulator, averaging 12.288 MHz
  logic [MCLK_ACC_W-1:0] acc_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
      mclk    <= 1'b0;
    end else if (ce) begin
      acc_reg <= acc_reg + MCLK_ACC_INC;
      mclk    <= acc_reg[MCLK_ACC_W-1];
    end
  end

  // pin synchronisers, two flops each
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic       rx_s1_reg;
  logic       rx_s2_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
    end else if (ce) begin
      s1_reg    <= {bclk_i, playback_channel_clock_i, record_channel_clock_i};
      s2_reg    <= s1_reg;
      rx_s1_reg <= record_serial_data;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  // local bit/channel clock generator for slave mode
  localparam int HALF_W = $clog2(BCLK_HALF + 1);
  logic [HALF_W-1:0] half_cnt_reg;
  logic              gen_bclk_reg;
  logic [4:0]        slot_cnt_reg;
  logic              gen_lrc_reg;
  logic              half_hit;
  assign half_hit = (half_cnt_reg == HALF_W'(BCLK_HALF - 1));
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt_reg <= '0;
      gen_bclk_reg <= 1'b0;
      slot_cnt_reg <= '0;
      gen_lrc_reg  <= 1'b0;
    end else if (ce) begin
      half_cnt_reg <= half_hit ? '0 : half_cnt_reg + HALF_W'(1);
      if (half_hit) begin
        gen_bclk_reg <= ~gen_bclk_reg;
        if (gen_bclk_reg) begin
          // channel clock changes on bit clock falling edge
          slot_cnt_reg <= slot_cnt_reg + 5'h01;
          if (slot_cnt_reg == 5'(SLOT_W - 1))
            gen_lrc_reg <= ~gen_lrc_reg;
        end
      end
    end
  end

  // select clock source by mode
  logic bclk_now;
  logic lrc_now;
  logic bclk_prev_reg;
  logic bclk_rise;
  logic bclk_fall;
  assign bclk_now  = codec_master ? s2_reg[2] : gen_bclk_reg;
  assign lrc_now   = codec_master ? s2_reg[1] : gen_lrc_reg;
  assign bclk_rise = bclk_now & ~bclk_prev_reg;
  assign bclk_fall = ~bclk_now & bclk_prev_reg;

  // pins: drive only in slave mode
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bclk_prev_reg             <= 1'b0;
      bclk_o                    <= 1'b0;
      bclk_oe                   <= 1'b0;
      playback_channel_clock_o  <= 1'b0;
      playback_channel_clock_oe <= 1'b0;
      record_channel_clock_o    <= 1'b0;
      record_channel_clock_oe   <= 1'b0;
    end else if (ce) begin
      bclk_prev_reg             <= bclk_now;
      bclk_o                    <= gen_bclk_reg;
      bclk_oe                   <= ~codec_master;
      playback_channel_clock_o  <= gen_lrc_reg;
      playback_channel_clock_oe <= ~codec_master;
      record_channel_clock_o    <= gen_lrc_reg;
      record_channel_clock_oe   <= ~codec_master;
    end
  end

  // serial data engine; shared channel clock for both directions
  logic tx_bit;
  acsi_shift #(
    .WIDTH(WIDTH)
  ) u_shift (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .bclk_fall (bclk_fall),
    .bclk_rise (bclk_rise),
    .lrc       (lrc_now),
    .rx_bit    (rx_s2_reg),
    .tx_left   (play_left),
    .tx_right  (play_right),
    .tx_bit    (tx_bit),
    .rx_left   (rec_left),
    .rx_right  (rec_right),
    .rx_valid  (rec_valid),
    .tx_load   (play_take)
  );
  assign playback_serial_data = tx_bit;

  // mute release once configured and frames observed
  logic       lrc_prev_reg;
  logic [2:0] frame_cnt_reg;
  logic       clocks_ok;
  assign clocks_ok = (frame_cnt_reg == 3'(SETTLE_FRAMES));
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrc_prev_reg  <= 1'b0;
      frame_cnt_reg <= '0;
      mute_n        <= 1'b0;
    end else if (ce) begin
      lrc_prev_reg <= lrc_now;
      if (lrc_now && !lrc_prev_reg && !clocks_ok)
        frame_cnt_reg <= frame_cnt_reg + 3'h1;
      mute_n <= cfg_done & clocks_ok & unmute_req;
    end
  end
endmodule

/* tb/acsi_sva.sv */
// Purpose: port-level checks of the serial audio link
// Assumes: ce held high; mode changes only inside reset
// Notes:   bound to acsi_top
`timescale 1ns/10ps
module acsi_sva import acsi_pkg::*; #(
  parameter int WIDTH = SAMPLE_W
) (
  input wire logic             ref_clk,                   // clock
  input wire logic             arst_n,                    // reset
  input wire logic             ce,                        // enable
  input wire logic             codec_master,              // mode
  input wire logic             cfg_done,                  // config done
  input wire logic             unmute_req,                // unmute wish
  input wire logic             mclk,                      // master clock
  input wire logic             bclk_o,                    // bit clock
  input wire logic             bclk_oe,                   // bit clock enable
  input wire logic             playback_channel_clock_o,  // channel clock
  input wire logic             playback_channel_clock_oe, // its enable
  input wire logic             record_channel_clock_o,    // record channel clock
  input wire logic             record_channel_clock_oe,   // its enable
  input wire logic             playback_serial_data,      // playback data
  input wire logic             mute_n,                    // mute, low mutes
  input wire logic [WIDTH-1:0] rec_left,                  // record left
  input wire logic [WIDTH-1:0] rec_right,                 // record right
  input wire logic             rec_valid,                 // record pair
  input wire logic             play_take                  // playback pair
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_oe_mode: assert property ($past(arst_n, 2) && $past(ce) |-> bclk_oe == !$past(codec_master))
    else $error("bit clock enable wrong");
  a_oe_group: assert property (playback_channel_clock_oe == bclk_oe && record_channel_clock_oe == bclk_oe)
    else $error("channel clock enables differ");
  a_rec_lrc: assert property (bclk_oe |-> record_channel_clock_o == playback_channel_clock_o)
    else $error("channel clocks differ");
  a_mclk_rate: assert property ($changed(mclk) |=> $stable(mclk)[*3] ##[1:2] $changed(mclk))
    else $error("master clock half period wrong");
  a_bclk_half: assert property ($changed(bclk_o) && bclk_oe |=> $stable(bclk_o)[*8] ##8 $changed(bclk_o))
    else $error("bit clock half period wrong");
  a_lrc_fall: assert property (bclk_oe && $changed(playback_channel_clock_o) |-> !bclk_o)
    else $error("channel clock moved off falling edge");
  a_data_fall: assert property (bclk_oe && $changed(playback_serial_data) |-> !bclk_o)
    else $error("data moved off falling edge");
  a_mute_gate: assert property ($rose(mute_n) |-> $past(cfg_done) && $past(unmute_req))
    else $error("unmuted too early");
  a_rec_hold: assert property ($changed(rec_right) |-> rec_valid)
    else $error("record word moved without valid");
  a_left_quiet: assert property ($changed(rec_left) |-> !rec_valid)
    else $error("record left moved at right completion");
  a_valid_one: assert property (rec_valid |=> !rec_valid)
    else $error("record valid too long");
  a_take_one: assert property (play_take |=> !play_take)
    else $error("playback take too long");
endmodule

bind acsi_top acsi_sva #(.WIDTH(WIDTH)) chk (.*);

/* tb/acsi_codec_model.sv */
// Purpose: behavioural stereo codec on the serial stream
// Assumes: 160 ns bit clock when the codec makes the clocks
// Notes:   drives clocks only while the logic does not
`timescale 1ns/10ps
module acsi_codec_model (
  input  wire logic        bclk_o,   // logic bit clock
  input  wire logic        bclk_oe,  // logic drives bit clock
  input  wire logic        lrc_o,    // logic channel clock
  input  wire logic        lrc_oe,   // logic drives channel clock
  input  wire logic        pb_data,  // playback data
  input  wire logic [23:0] rec_l,    // left word to send
  input  wire logic [23:0] rec_r,    // right word to send
  output logic             bclk,     // bit clock wire
  output logic             lrc,      // channel clock wire
  output logic             rec_data, // record data
  output logic [23:0]      got_l,    // last playback left
  output logic [23:0]      got_r     // last playback right
);
  logic        gb = 1'b0;
  logic        gl = 1'b0;
  logic        lrc_d = 1'b0;
  logic [4:0]  gc = 5'h00;
  logic [5:0]  cnt = 6'h3F;
  logic [23:0] sh = 24'h000000;
  always #80 gb = ~gb;
  always @(negedge gb) begin
    gc <= gc + 5'h01;
    if (&gc) gl <= ~gl;
  end
  assign bclk = bclk_oe ? bclk_o : gb;
  assign lrc  = lrc_oe ? lrc_o : gl;
  always @(negedge bclk) begin
    #1;
    cnt = (lrc != lrc_d) ? 6'h00 : cnt + 6'h01;
    lrc_d = lrc;
    rec_data = (cnt inside {[1:24]}) ? (lrc ? rec_r[24-cnt] : rec_l[24-cnt]) : 1'b0;
  end
  always @(posedge bclk) begin
    #1;
    if (cnt inside {[1:24]}) sh = {sh[22:0], pb_data};
    if (cnt == 6'h18 && lrc) got_r = sh;
    if (cnt == 6'h18 && !lrc) got_l = sh;
  end
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench for acsi_top
// Assumes: codec model on the serial pins
// Notes:   both clock modes, mute release, master clock rate
`timescale 1ns/10ps
module testbench import acsi_pkg::*; ;
  logic        ref_clk = 1'b0, arst_n = 1'b0, ce = 1'b1, codec_master = 1'b0, cfg_done = 1'b0, unmute_req = 1'b1;
  logic [23:0] play_left = 24'hA5C3F1, play_right = 24'h3C0F5A, rl = 24'hC1E2D3, rr = 24'h1B2A39;
  logic [23:0] rec_left, rec_right, got_l, got_r;
  logic        play_take, rec_valid, mclk, bclk_i, bclk_o, bclk_oe, mute_n, playback_serial_data, record_serial_data;
  logic        playback_channel_clock_i, playback_channel_clock_o, playback_channel_clock_oe;
  logic        record_channel_clock_i, record_channel_clock_o, record_channel_clock_oe;
  int          failures = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  assign record_channel_clock_i = playback_channel_clock_i;
  acsi_top dut (.*);
  acsi_codec_model codec (.bclk_o(bclk_o), .bclk_oe(bclk_oe), .lrc_o(playback_channel_clock_o),
    .lrc_oe(playback_channel_clock_oe), .pb_data(playback_serial_data), .rec_l(rl), .rec_r(rr),
    .bclk(bclk_i), .lrc(playback_channel_clock_i), .rec_data(record_serial_data), .got_l(got_l), .got_r(got_r));
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic do_reset(input logic mode);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    codec_master <= mode;
    repeat (8) @(posedge ref_clk);
    cmp({mute_n, mclk, bclk_oe}, 24'h0);
    arst_n <= 1'b1;
  endtask
  task automatic link_pairs(input logic mode);
    int k;
    int n;
    int last;
    int span;
    int exp_span;
    do_reset(mode);
    repeat (4) @(posedge ref_clk);
    cmp(bclk_oe, !mode);
    n = 3;
    last = 0;
    span = 0;
    // codec bit clock is 160 ns, 16 ref_clk cycles
    exp_span = mode ? 2 * SLOT_W * 16 : 2 * SLOT_W * 2 * BCLK_HALF;
    k = 0;
    while (n > 0 && k < 20000) begin
      @(posedge ref_clk);
      k++;
      if (rec_valid === 1'b1) begin
        n--;
        span = k - last;
        last = k;
      end
    end
    cmp(n, 0);
    cmp(span >= exp_span - 1 && span <= exp_span + 1, 1);
    cmp(got_l, play_left);
    cmp(got_r, play_right);
    cmp(rec_left, rl);
    cmp(rec_right, rr);
  endtask
  task automatic mclk_rate();
    int n;
    logic p;
    n = 0;
    p = mclk;
    repeat (10000) begin
      @(posedge ref_clk);
      if (mclk === 1'b1 && p === 1'b0) n++;
      p = mclk;
    end
    cmp(n >= 1228 && n <= 1229, 1);
  endtask
  task automatic mute_release();
    int k;
    int lo;
    // fourth channel clock rise after reset: first after one slot, then one per frame
    lo = (2 * SETTLE_FRAMES - 1) * SLOT_W * 2 * BCLK_HALF;
    cmp(24'(CODEC_I2C_ADDR), 24'h00001A);
    cmp(mute_n, 0);
    cfg_done <= 1'b1;
    k = 0;
    while (mute_n !== 1'b1 && k < 14000) begin
      @(posedge ref_clk);
      k++;
    end
    cmp(mute_n, 1);
    cmp(k <= 3, 1);
    unmute_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp(mute_n, 0);
    unmute_req <= 1'b1;
    do_reset(1'b0);
    k = 0;
    while (mute_n !== 1'b1 && k < 14000) begin
      @(posedge ref_clk);
      k++;
    end
    cmp(k >= lo && k <= lo + 8, 1);
  endtask
  initial begin
    link_pairs(1'b0);
    mclk_rate();
    mute_release();
    rl <= 24'h8E7D01;
    rr <= 24'h70A5FE;
    play_left <= 24'h123456;
    link_pairs(1'b1);
    mclk_rate();
    print_verdict();
  end
  initial begin
    #600000;
    failures++;
    print_verdict();
  end
endmodule
